// ---- design/barrel_shift_core.sv ----
/*
  combinational barrel shifter for the register form of the second operand.
  assumes the requester holds its inputs stable for the cycle it samples the result.
*/
`default_nettype none
module barrel_shift_core
  import operand_shift_pkg::*;
(
  shift_bus_if.shifter_end bus
);
  // wide shifts let oversize lengths fall out naturally as zero or sign fill
  logic [2*WORD_W-1:0] left_wide;
  logic [WORD_W:0] right_wide;
  logic signed [WORD_W:0] arith_wide;
  logic [2*WORD_W-1:0] rot_wide;
  logic [4:0] rot_amount;
  logic zero_len;

  assign left_wide = {32'h0000_0000, bus.source} << bus.length;
  assign right_wide = {bus.source, 1'b0} >> bus.length;
  assign arith_wide = $signed({bus.source, 1'b0}) >>> bus.length;
  assign rot_amount = bus.length[4:0];
  assign rot_wide = {bus.source, bus.source} >> rot_amount;
  assign zero_len = (bus.length == LEN_ZERO);

  always_comb begin
    bus.result = bus.source;
    bus.carry_out = bus.carry_in;
    bus.carry_changes = 1'b0;
    case (bus.kind)
      KIND_LOGICAL_SHIFT_LEFT: begin
        bus.result = zero_len ? bus.source : left_wide[WORD_W-1:0];
        bus.carry_out = zero_len ? bus.carry_in : left_wide[WORD_W];
        bus.carry_changes = !zero_len;
      end
      KIND_LOGICAL_SHIFT_RIGHT: begin
        bus.result = right_wide[WORD_W:1];
        bus.carry_out = zero_len ? bus.carry_in : right_wide[0];
        bus.carry_changes = !zero_len;
      end
      KIND_ARITH_SHIFT_RIGHT: begin
        bus.result = arith_wide[WORD_W:1];
        bus.carry_out = zero_len ? bus.carry_in : arith_wide[0];
        bus.carry_changes = !zero_len;
      end
      KIND_ROTATE_RIGHT: begin
        bus.result = rot_wide[WORD_W-1:0];
        bus.carry_out = zero_len ? bus.carry_in : rot_wide[WORD_W-1];
        bus.carry_changes = !zero_len;
      end
      KIND_ROTATE_RIGHT_EXTEND: begin
        bus.result = {bus.carry_in, bus.source[WORD_W-1:1]};
        bus.carry_out = bus.source[0];
        bus.carry_changes = 1'b1;
      end
      default: begin
        bus.result = bus.source;
        bus.carry_out = bus.carry_in;
        bus.carry_changes = 1'b0;
      end
    endcase
  end
endmodule : barrel_shift_core
`default_nettype wire

// ---- design/operand_shift_pkg.sv ----
/*
  shared types and constants of the operand shifter unit.
  assumes a single core clock domain and a 32-bit datapath.
*/
`default_nettype none
package operand_shift_pkg;
  localparam int WORD_W = 32;
  localparam int LEN_W = 8;
  localparam int IMM_W = 12;
  localparam logic [WORD_W-1:0] OPERAND_RST = 32'h0000_0000;
  localparam logic CARRY_RST = 1'b0;
  localparam logic [LEN_W-1:0] LEN_ZERO = 8'h00;
  localparam logic [LEN_W-1:0] LEN_WORD = 8'h20;
  localparam logic [LEN_W-1:0] LEN_BEYOND_WORD = 8'h21;
  // immediate field layout: [11:10] form, [9:8] replicate pattern, [11:7] rotate amount
  localparam int IMM_FORM_HI = 11;
  localparam int IMM_FORM_LO = 10;
  localparam int IMM_PAT_HI = 9;
  localparam int IMM_PAT_LO = 8;
  localparam int IMM_ROT_LO = 7;
  localparam logic [1:0] IMM_FORM_REPLICATE = 2'h0;
  localparam logic [1:0] IMM_PAT_PLAIN = 2'h0;
  localparam logic [1:0] IMM_PAT_EVEN_BYTES = 2'h1;
  localparam logic [1:0] IMM_PAT_ODD_BYTES = 2'h2;
  localparam logic [1:0] IMM_PAT_ALL_BYTES = 2'h3;

  typedef enum logic [2:0] {
    KIND_NONE,
    KIND_LOGICAL_SHIFT_LEFT,
    KIND_LOGICAL_SHIFT_RIGHT,
    KIND_ARITH_SHIFT_RIGHT,
    KIND_ROTATE_RIGHT,
    KIND_ROTATE_RIGHT_EXTEND
  } shift_kind_type;
endpackage : operand_shift_pkg
`default_nettype wire

// ---- design/operand_shifter_unit.sv ----
/*
  flexible second operand unit: decodes an immediate field or shifts a source
  register, and returns the operand with the shifter carry one cycle later.
  assumes the execute stage presents one request per valid cycle and applies
  carry_out to its flag only when carry_update is high.
*/
// Functional notes
// - accept any byte shifted within word (code forces the byte's bit 7 high and rotates right by 8 to 31 only)
// - produce replicated byte immediate patterns
// - shifted immediate above 255 sets carry to its bit 31
// - support all five shift kinds and lengths
// - no shift passes source unaltered
// - shift result delivered, source never written
// - zero length shift keeps carry
// - arithmetic right fills with sign bit
// - arithmetic right carry is bit n-1
// - arithmetic right 32 plus gives sign
// - logical right zero fill, carry bit n-1
// - logical left carry bit 32-n
// - rotate right wraps, 32 keeps source
// - extend rotate inserts carry at top
`default_nettype none
module operand_shifter_unit
  import operand_shift_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic op_valid,
  input wire logic use_immediate,
  input wire logic flag_setting_logical,
  input wire logic [IMM_W-1:0] immediate_field,
  input wire shift_kind_type shift_kind,
  input wire logic [LEN_W-1:0] shift_length,
  input wire logic [WORD_W-1:0] shift_source_register,
  input wire logic carry_in,
  output logic [WORD_W-1:0] flexible_second_operand,
  output logic carry_out,
  output logic carry_update,
  output logic operand_valid
);
  // ----------------------------------------
  // immediate decode
  // ----------------------------------------
  logic [7:0] imm_byte;
  logic [1:0] imm_form;
  logic [1:0] imm_pattern;
  logic [4:0] imm_rot;
  logic imm_is_shifted;
  logic [2*WORD_W-1:0] imm_rot_wide;
  logic [WORD_W-1:0] imm_shifted_value;
  logic [WORD_W-1:0] imm_replicated_value;
  logic [WORD_W-1:0] imm_value;

  assign imm_byte = immediate_field[7:0];
  assign imm_form = immediate_field[IMM_FORM_HI:IMM_FORM_LO];
  assign imm_pattern = immediate_field[IMM_PAT_HI:IMM_PAT_LO];
  assign imm_rot = immediate_field[IMM_FORM_HI:IMM_ROT_LO];
  assign imm_is_shifted = (imm_form != IMM_FORM_REPLICATE);
  assign imm_rot_wide = {24'h00_0000, 1'b1, imm_byte[6:0], 24'h00_0000, 1'b1, imm_byte[6:0]} >> imm_rot;
  assign imm_shifted_value = imm_rot_wide[WORD_W-1:0];
  assign imm_replicated_value =
    (imm_pattern == IMM_PAT_EVEN_BYTES) ? {8'h00, imm_byte, 8'h00, imm_byte} :
    (imm_pattern == IMM_PAT_ODD_BYTES) ? {imm_byte, 8'h00, imm_byte, 8'h00} :
    (imm_pattern == IMM_PAT_ALL_BYTES) ? {imm_byte, imm_byte, imm_byte, imm_byte} :
    {24'h00_0000, imm_byte};
  assign imm_value = imm_is_shifted ? imm_shifted_value : imm_replicated_value;

  // ----------------------------------------
  // register shifter
  // ----------------------------------------
  shift_bus_if shift_bus ();
  assign shift_bus.kind = shift_kind;
  assign shift_bus.length = shift_length;
  assign shift_bus.source = shift_source_register;
  assign shift_bus.carry_in = carry_in;

  barrel_shift_core shift_core (
    .bus(shift_bus)
  );

  // ----------------------------------------
  // operand and carry selection
  // ----------------------------------------
  logic [WORD_W-1:0] operand_next;
  logic carry_changes;
  logic carry_update_next;
  logic carry_out_next;
  logic [WORD_W-1:0] operand_reg;
  logic carry_out_reg;
  logic carry_update_reg;
  logic operand_valid_reg;

  // result is a copy, source stays untouched
  assign operand_next = use_immediate ? imm_value : shift_bus.result;
  // only shifted immediates move carry; these are always above 255
  assign carry_changes = use_immediate ? imm_is_shifted : shift_bus.carry_changes;
  assign carry_update_next = op_valid && flag_setting_logical && carry_changes;
  // incoming carry passes when not updated
  assign carry_out_next = !carry_update_next ? carry_in :
                          use_immediate ? imm_value[WORD_W-1] : shift_bus.carry_out;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      operand_reg <= OPERAND_RST;
      carry_out_reg <= CARRY_RST;
      carry_update_reg <= 1'b0;
      operand_valid_reg <= 1'b0;
    end else begin
      operand_reg <= operand_next;
      carry_out_reg <= carry_out_next;
      carry_update_reg <= carry_update_next;
      operand_valid_reg <= op_valid;
    end
  end

  assign flexible_second_operand = operand_reg;
  assign carry_out = carry_out_reg;
  assign carry_update = carry_update_reg;
  assign operand_valid = operand_valid_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic reg_req;
  logic flag_req;
  logic [4:0] left_ref_idx;
  assign reg_req = op_valid && !use_immediate;
  assign flag_req = reg_req && flag_setting_logical;
  assign left_ref_idx = 5'(6'h20 - {1'b0, shift_length[4:0]});

  AST_IMM_ALL_BYTES: assert property (@(posedge ref_clk) disable iff (!nrst)
    op_valid && use_immediate && immediate_field[11:8] == 4'h3 |=>
      operand_valid && flexible_second_operand == {4{$past(immediate_field[7:0])}})
    else $error("replicated immediate wrong");

  AST_IMM_CARRY: assert property (@(posedge ref_clk) disable iff (!nrst)
    op_valid && use_immediate && flag_setting_logical |=>
      (carry_update == $past(imm_is_shifted)) &&
      (carry_update ? (carry_out == flexible_second_operand[31] && flexible_second_operand > 32'h0000_00FF)
                    : carry_out == $past(carry_in)))
    else $error("immediate carry wrong");

  AST_PASS_THROUGH: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_req && (shift_kind == KIND_NONE || shift_length == LEN_ZERO) && shift_kind != KIND_ROTATE_RIGHT_EXTEND |=>
      flexible_second_operand == $past(shift_source_register) && !carry_update)
    else $error("unshifted operand altered");

  AST_ZERO_LEN_CARRY: assert property (@(posedge ref_clk) disable iff (!nrst)
    flag_req && shift_length == LEN_ZERO && shift_kind != KIND_ROTATE_RIGHT_EXTEND |=>
      carry_out == $past(carry_in))
    else $error("zero length changed carry");

  AST_ARITH_BIG: assert property (@(posedge ref_clk) disable iff (!nrst)
    flag_req && shift_kind == KIND_ARITH_SHIFT_RIGHT && shift_length >= LEN_WORD |=>
      flexible_second_operand == {32{$past(shift_source_register[31])}} &&
      carry_update && carry_out == $past(shift_source_register[31]))
    else $error("arith shift beyond word wrong");

  AST_RIGHT_BEYOND: assert property (@(posedge ref_clk) disable iff (!nrst)
    flag_req && shift_kind == KIND_LOGICAL_SHIFT_RIGHT && shift_length >= LEN_BEYOND_WORD |=>
      flexible_second_operand == 32'h0000_0000 && carry_update && !carry_out)
    else $error("logical right beyond word wrong");

  AST_LEFT_CARRY: assert property (@(posedge ref_clk) disable iff (!nrst)
    flag_req && shift_kind == KIND_LOGICAL_SHIFT_LEFT && shift_length != LEN_ZERO && shift_length < LEN_WORD |=>
      carry_out == $past(shift_source_register[left_ref_idx]) && flexible_second_operand[0] == 1'b0)
    else $error("logical left carry wrong");

  AST_ROT_WORD: assert property (@(posedge ref_clk) disable iff (!nrst)
    flag_req && shift_kind == KIND_ROTATE_RIGHT && shift_length == LEN_WORD |=>
      flexible_second_operand == $past(shift_source_register) && carry_out == $past(shift_source_register[31]))
    else $error("rotate by word wrong");

  AST_EXTEND: assert property (@(posedge ref_clk) disable iff (!nrst)
    flag_req && shift_kind == KIND_ROTATE_RIGHT_EXTEND |=>
      flexible_second_operand == {$past(carry_in), $past(shift_source_register[31:1])} &&
      carry_out == $past(shift_source_register[0]))
    else $error("extend rotate wrong");

  AST_QUALIFIER: assert property (@(posedge ref_clk) disable iff (!nrst)
    !(op_valid && flag_setting_logical) |=> !carry_update && carry_out == $past(carry_in))
    else $error("carry moved without qualifier");
endmodule : operand_shifter_unit
`default_nettype wire

// ---- design/shift_bus_if.sv ----
/*
  carrier between the operand shifter top and its barrel shift core.
  assumes both ends sit in the same clock domain; all signals are combinational.
*/
`default_nettype none
interface shift_bus_if;
  import operand_shift_pkg::*;
  shift_kind_type kind;
  logic [LEN_W-1:0] length;
  logic [WORD_W-1:0] source;
  logic carry_in;
  logic [WORD_W-1:0] result;
  logic carry_out;
  logic carry_changes;
  modport requester_end (output kind, output length, output source, output carry_in,
                         input result, input carry_out, input carry_changes);
  modport shifter_end (input kind, input length, input source, input carry_in,
                       output result, output carry_out, output carry_changes);
endinterface : shift_bus_if
`default_nettype wire

// ---- tb/flag_logic_model.sv ----
/*
  behavioural carry flag of the execute stage that consumes the operand unit.
  assumes the unit's outputs are registered on the same rising edge of ref_clk.
*/
`default_nettype none
module flag_logic_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic operand_valid,
  input wire logic carry_out,
  input wire logic carry_update,
  output logic carry_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // carry flag
  // ----------------------------------------
  // flag only follows qualifier
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      carry_flag <= 1'b0;
    end else if (operand_valid && carry_update) begin
      carry_flag <= carry_out;
    end
  end
endmodule : flag_logic_model
`default_nettype wire

// ---- tb/testbench.sv ----
/*
  self-checking bench of the operand shifter unit with a carry flag model.
  assumes one request per cycle and the answer just after the same edge that takes it.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import operand_shift_pkg::*;
  logic ref_clk = 1'b0, nrst = 1'b0, op_valid = 1'b0, use_immediate = 1'b0, fsl = 1'b0, carry_in;
  logic [IMM_W-1:0] imm = 12'h000;
  shift_kind_type kind = KIND_NONE;
  logic [LEN_W-1:0] len = 8'h00;
  logic [WORD_W-1:0] src = 32'h0000_0000, operand;
  logic carry_out, carry_update, operand_valid;
  int error_cnt = 0, tests_run = 0;
  operand_shifter_unit i_operand_shifter_unit (.ref_clk(ref_clk), .nrst(nrst), .op_valid(op_valid),
    .use_immediate(use_immediate), .flag_setting_logical(fsl), .immediate_field(imm), .shift_kind(kind),
    .shift_length(len), .shift_source_register(src), .carry_in(carry_in), .flexible_second_operand(operand),
    .carry_out(carry_out), .carry_update(carry_update), .operand_valid(operand_valid));
  flag_logic_model i_flag_logic_model (.ref_clk(ref_clk), .nrst(nrst), .operand_valid(operand_valid),
    .carry_out(carry_out), .carry_update(carry_update), .carry_flag(carry_in));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // reference and compare
  // ----------------------------------------
  function automatic logic [33:0] ref_op(logic im, logic [11:0] f, shift_kind_type k, logic [7:0] n,
                                         logic [31:0] s, logic ci);
    logic u, c;
    logic [31:0] r, v;
    int m;
    u = (n != 8'h00);
    r = s;
    c = ci;
    if (im) begin
      v = {24'h00_0000, 1'b1, f[6:0]};
      m = f[11:7];
      u = (f[11:10] != 2'h0);
      case (f[9:8])
        2'h0: r = u ? ((v >> m) | (v << (32 - m))) : {24'h00_0000, f[7:0]};
        2'h1: r = u ? ((v >> m) | (v << (32 - m))) : {8'h00, f[7:0], 8'h00, f[7:0]};
        2'h2: r = u ? ((v >> m) | (v << (32 - m))) : {f[7:0], 8'h00, f[7:0], 8'h00};
        default: r = u ? ((v >> m) | (v << (32 - m))) : {4{f[7:0]}};
      endcase
      c = r[31];
    end else begin
      case (k)
        KIND_LOGICAL_SHIFT_LEFT: if (u) begin r = (n >= 32) ? 32'h0 : s << n; c = (n > 32) ? 1'b0 : s[32 - n]; end
        KIND_LOGICAL_SHIFT_RIGHT: if (u) begin r = (n >= 32) ? 32'h0 : s >> n; c = (n > 32) ? 1'b0 : s[n - 1]; end
        KIND_ARITH_SHIFT_RIGHT: if (u) begin r = (n >= 32) ? {32{s[31]}} : 32'($signed(s) >>> n);
          c = (n >= 32) ? s[31] : s[n - 1]; end
        KIND_ROTATE_RIGHT: if (u) begin m = n % 32; r = (s >> m) | (s << (32 - m)); c = r[31]; end
        KIND_ROTATE_RIGHT_EXTEND: begin u = 1'b1; r = {ci, s[31:1]}; c = s[0]; end
        default: u = 1'b0;
      endcase
    end
    return {u, c, r};
  endfunction : ref_op

  task automatic cmp(logic [31:0] got, logic [31:0] exp, string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  // one request, taken at the next edge and judged 1 ns after that same edge
  task automatic op(logic im, logic f_s, logic [11:0] f, shift_kind_type k, logic [7:0] n, logic [31:0] s);
    logic [33:0] e;
    logic u;
    logic ci;
    // the flag may still move at the taking edge, so keep the carry the unit samples there
    ci = carry_in;
    e = ref_op(im, f, k, n, s, ci);
    u = e[33] & f_s;
    op_valid = 1'b1; use_immediate = im; fsl = f_s; imm = f; kind = k; len = n; src = s;
    @(posedge ref_clk) #1;
    cmp({31'h0, operand_valid}, 32'h1, "valid");
    cmp(operand, e[31:0], "operand");
    cmp({31'h0, carry_update}, {31'h0, u}, "update");
    cmp({31'h0, carry_out}, {31'h0, u ? e[32] : ci}, "carry");
  endtask : op
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic check_reset();
    cmp({operand[31:1], operand[0] | carry_out | carry_update | operand_valid}, 32'h0, "reset");
  endtask : check_reset

  task automatic run_immediates();
    // 12'h455 lands the byte's top bit in bit 31, so carry is driven high once
    logic [11:0] tab [9] = '{12'h3AB, 12'h0AB, 12'h1C5, 12'h27E, 12'h4FF, 12'hC01, 12'hFFF, 12'h800, 12'h455};
    foreach (tab[i]) op(1'b1, 1'b1, tab[i], KIND_NONE, 8'h00, 32'h0);
    op(1'b1, 1'b0, 12'hC80, KIND_NONE, 8'h00, 32'h0);
  endtask : run_immediates

  task automatic run_shifts();
    shift_kind_type ks [5] = '{KIND_NONE, KIND_LOGICAL_SHIFT_LEFT, KIND_LOGICAL_SHIFT_RIGHT,
                              KIND_ARITH_SHIFT_RIGHT, KIND_ROTATE_RIGHT};
    logic [7:0] ls [8] = '{8'h00, 8'h01, 8'h03, 8'h1F, 8'h20, 8'h21, 8'h40, 8'h43};
    foreach (ks[i]) foreach (ls[j]) begin
      op(1'b0, 1'b1, 12'h000, ks[i], ls[j], 32'h8000_0001);
      op(1'b0, 1'b1, 12'h000, ks[i], ls[j], 32'h43A5_0F96);
    end
  endtask : run_shifts

  task automatic run_extend();
    // carry into the top bit needs the flag set first, so a right shift loads it
    op(1'b0, 1'b1, 12'h000, KIND_LOGICAL_SHIFT_RIGHT, 8'h01, 32'h0000_0001);
    op(1'b0, 1'b1, 12'h000, KIND_NONE, 8'h00, 32'h0);
    op(1'b0, 1'b1, 12'h000, KIND_ROTATE_RIGHT_EXTEND, 8'h05, 32'h0000_0002);
    op(1'b0, 1'b1, 12'h000, KIND_ROTATE_RIGHT_EXTEND, 8'h00, 32'hF000_0001);
    op(1'b0, 1'b1, 12'h000, KIND_NONE, 8'h00, 32'h0);
    op(1'b0, 1'b1, 12'h000, KIND_ROTATE_RIGHT_EXTEND, 8'h00, 32'h7000_0000);
  endtask : run_extend

  task automatic run_no_update();
    op(1'b0, 1'b1, 12'h000, KIND_LOGICAL_SHIFT_RIGHT, 8'h01, 32'h0000_0001);
    op(1'b0, 1'b0, 12'h000, KIND_LOGICAL_SHIFT_LEFT, 8'h04, 32'hF000_0000);
    op(1'b0, 1'b0, 12'h000, KIND_ROTATE_RIGHT_EXTEND, 8'h00, 32'h0000_0000);
    op_valid = 1'b0;
    fsl = 1'b1;
    @(posedge ref_clk) #1;
    cmp({30'h0, operand_valid, carry_update}, 32'h0, "idle");
    cmp({31'h0, carry_out}, {31'h0, carry_in}, "idle carry");
  endtask : run_no_update

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // main sequence and hang guard
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    check_reset();
    nrst = 1'b1;
    run_immediates();
    run_shifts();
    run_extend();
    run_no_update();
    print_verdict();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    $display("FAIL %0t run did not finish", $time);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
